/* design/aom_top.sv */
`include "aom_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module aom_top
  import aom_pkg::*;
(
  // Master clock domain
  input wire logic clock,
  input wire logic sys_rst,
  // Serial link domain
  input wire logic link_clock,
  input wire logic link_mode_wr,
  input wire logic [2:0] link_mode_addr,
  input wire logic [7:0] link_mode_wdata,
  input wire logic link_data_rd,
  input wire logic [2:0] link_rd_chan,
  output logic [7:0] link_mode_rdata_q,
  output logic link_rd_valid_q,
  output logic [7:0] link_rd_status_q,
  output logic [23:0] link_rd_data_q,
  output logic link_rd_with_status_q,
  output logic link_rd_wide_q,
  output logic link_cont_read_q,
  // Modulator and channel setup
  input wire logic [23:0] adc_result,
  input wire logic adc_over,
  input wire logic adc_under,
  input wire logic [7:0] chan_enable,
  input wire logic xtal_mode,
  // Calibration readout
  input wire logic [4:0] cal_sel,
  output logic [23:0] cal_value_q,
  // Device pins
  output logic rdy_n_q,
  output logic mclk_out_q,
  output logic mclk_out_oe_n_q,
  output logic powerdown_q
);

  // ****************************************
  // Helpers
  // ****************************************
  // Next enabled channel after cur, cur itself if none
  function automatic logic [2:0] next_en(input logic [2:0] cur,
                                         input logic [7:0] en);
    logic [2:0] idx;
    logic [2:0] res;
    logic hit;
    res = cur;
    hit = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = 3'(cur + 3'(i));
      if (!hit && en[idx]) begin
        res = idx;
        hit = 1'b1;
      end
    end
    return res;
  endfunction

  // Clamp and width shaping of a raw result
  function automatic logic [23:0] shape(input logic [23:0] raw,
                                        input logic over,
                                        input logic under,
                                        input logic clamp,
                                        input logic wide);
    logic [23:0] v;
    v = raw;
    if (clamp && over) begin
      v = 24'hffffff;
    end else if (clamp && under) begin
      v = 24'h000000;
    end
    if (!wide) begin
      v = {8'h00, v[23:8]};
    end
    return v;
  endfunction

  localparam logic [15:0] CONV_CYC = 16'(`AOM_CONV_CYC - 1);
  localparam logic [15:0] CAL_CYC = 16'(`AOM_CAL_CYC - 1);

  // ****************************************
  // Link domain: reset sync and requests
  // ****************************************
  logic lrst_s1_q, lrst_q;          // Reset brought into link domain
  logic wr_tog_q;                   // Flips per mode write
  logic [2:0] wr_addr_q;            // Held write address
  logic [7:0] wr_data_q;            // Held write data
  logic rd_tog_q;                   // Flips per data read
  logic [2:0] rd_chan_q;            // Held read channel
  logic ack_s1_q, ack_s2_q, ack_s3_q; // Read answer sync
  logic mt_s1_q, mt_s2_q, mt_s3_q;  // Mode change toggle sync

  // Reset synchroniser for the link side
  always_ff @(posedge link_clock) begin
    lrst_s1_q <= sys_rst;
    lrst_q <= lrst_s1_q;
  end

  // Capture a mode write and flag it by toggle
  always_ff @(posedge link_clock) begin
    if (lrst_q) begin
      wr_tog_q <= 1'b0;
      wr_addr_q <= 3'h0;
      wr_data_q <= `AOM_MODE_RESET;
    end else if (link_mode_wr) begin
      wr_tog_q <= ~wr_tog_q;
      wr_addr_q <= link_mode_addr;
      wr_data_q <= link_mode_wdata;
    end
  end

  // Capture a data read request
  always_ff @(posedge link_clock) begin
    if (lrst_q) begin
      rd_tog_q <= 1'b0;
      rd_chan_q <= 3'h0;
    end else if (link_data_rd) begin
      rd_tog_q <= ~rd_tog_q;
      rd_chan_q <= link_rd_chan;
    end
  end

  // ****************************************
  // Master domain: crossings in
  // ****************************************
  logic wt_s1_q, wt_s2_q, wt_s3_q;  // Write toggle sync
  logic rt_s1_q, rt_s2_q, rt_s3_q;  // Read toggle sync
  logic xt_s1_q, xt_s2_q;           // Crystal strap sync

  // Two-stage synchronisers, plus an edge stage on the two toggles
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {wt_s1_q, wt_s2_q, wt_s3_q} <= 3'h0;
      {rt_s1_q, rt_s2_q, rt_s3_q} <= 3'h0;
      {xt_s1_q, xt_s2_q} <= 2'h0;
    end else begin
      {wt_s1_q, wt_s2_q, wt_s3_q} <= {wr_tog_q, wt_s1_q, wt_s2_q};
      {rt_s1_q, rt_s2_q, rt_s3_q} <= {rd_tog_q, rt_s1_q, rt_s2_q};
      {xt_s1_q, xt_s2_q} <= {xtal_mode, xt_s1_q};
    end
  end

  // ****************************************
  // Master domain: mode engine
  // ****************************************
  logic [7:0] mode_q;               // Operating mode control
  aom_state_t state_q;              // Engine state
  logic [15:0] cnt_q;               // Cycles left in operation
  logic [2:0] cur_ch_q;             // Channel being converted
  logic [7:0] ready_q;              // Per-channel ready flags
  logic [7:0] ready_d;
  logic [23:0] data_q [8];          // Channel data registers
  logic [7:0] stat_q [8];           // Channel status registers
  logic [23:0] cal_q [18];          // Self zs, self fs, 8 zs, 8 fs
  logic [23:0] hold_data_q;         // Read answer data
  logic [7:0] hold_stat_q;          // Read answer status
  logic ack_tog_q;                  // Flips per read answer
  logic mclk_div_q;                 // Clock-out toggle
  logic mode_tog_q;                 // Flips per mode change

  wire mode_wr = wt_s2_q ^ wt_s3_q;
  wire rd_req = rt_s2_q ^ rt_s3_q;
  wire aom_code_t code = aom_code_t'(mode_q[`AOM_CODE_HI:`AOM_CODE_LO]);
  wire aom_code_t new_code =
    aom_code_t'(wr_data_q[`AOM_CODE_HI:`AOM_CODE_LO]);
  wire run_en = ~(xt_s2_q & mode_q[`AOM_CLOCK_OUTPUT_DISABLE_BIT]);
  wire op_done = (state_q == AOM_ST_RUN) && (cnt_q == 16'h0) && run_en;
  wire is_conv = (code == AOM_CONT) || (code == AOM_SINGLE);
  wire is_cal = op_done && code[2];
  wire rd_lock = rd_req && (rd_chan_q == cur_ch_q);
  wire store_ok = op_done && is_conv && !rd_lock;
  wire [2:0] adv_ch = next_en(cur_ch_q, chan_enable);
  wire [23:0] shaped = shape(adc_result, adc_over, adc_under,
                             mode_q[`AOM_CLAMP_BIT],
                             mode_q[`AOM_WIDE_BIT]);
  wire [4:0] cal_idx = (code == AOM_SELF_ZS) ? 5'd0 :
                       (code == AOM_SELF_FS) ? 5'd1 :
                       (code == AOM_SYS_ZS) ? 5'(5'd2 + cur_ch_q) :
                       5'(5'd10 + cur_ch_q);
  wire [4:0] cal_rd_idx = (cal_sel > 5'd17) ? 5'd0 : cal_sel;

  // Mode register and engine state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q <= `AOM_MODE_RESET;
      state_q <= AOM_ST_IDLE;
      cnt_q <= 16'h0;
      cur_ch_q <= 3'h0;
    end else if (mode_wr) begin
      // Abort and start the newly written mode
      mode_q <= wr_data_q;
      cur_ch_q <= wr_addr_q;
      cnt_q <= new_code[2] ? CAL_CYC : CONV_CYC;
      case (new_code)
        AOM_IDLE: state_q <= AOM_ST_IDLE;
        AOM_STANDBY: state_q <= AOM_ST_STBY;
        default: state_q <= AOM_ST_RUN;
      endcase
    end else if (op_done) begin
      if (code == AOM_CONT) begin
        // Next enabled channel, back to back
        cur_ch_q <= adv_ch;
        cnt_q <= CONV_CYC;
      end else begin
        // Single and calibrations finish idle
        mode_q[`AOM_CODE_HI:`AOM_CODE_LO] <= 3'h0;
        state_q <= AOM_ST_IDLE;
      end
    end else if (state_q == AOM_ST_RUN && run_en) begin
      cnt_q <= 16'(cnt_q - 16'h1);
    end
  end

  // Announce each mode change so the link side copies a settled word
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_tog_q <= 1'b0;
    end else if (mode_wr || (op_done && code != AOM_CONT)) begin
      mode_tog_q <= ~mode_tog_q;
    end
  end

  // Ready flags: write clears all, calibration set beats read clear
  always_comb begin
    ready_d = ready_q;
    if (rd_req) begin
      ready_d[rd_chan_q] = 1'b0;
    end
    if (store_ok) begin
      ready_d[cur_ch_q] = 1'b1;
    end
    if (is_cal) begin
      ready_d = 8'hff;
    end
    if (mode_wr) begin
      ready_d = 8'h00;
    end
  end

  // Flags and ready pin
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ready_q <= 8'h00;
      rdy_n_q <= 1'b1;
    end else begin
      ready_q <= ready_d;
      rdy_n_q <= ~|ready_d;
    end
  end

  // Conversion results; a result colliding with a read of its own channel is lost
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        data_q[i] <= 24'h0;
        stat_q[i] <= 8'h0;
      end
    end else if (store_ok) begin
      data_q[cur_ch_q] <= shaped;
      // Ready bit is merged from the live flag when read
      stat_q[cur_ch_q] <= {cur_ch_q, 1'b0, 1'b0, 1'b0, adc_over,
                           adc_under};
    end
  end

  // Calibration coefficient storage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 18; i++) begin
        cal_q[i] <= 24'h0;
      end
    end else if (is_cal) begin
      cal_q[cal_idx] <= adc_result;
    end
  end

  // Read answers and calibration readout
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_data_q <= 24'h0;
      hold_stat_q <= 8'h0;
      ack_tog_q <= 1'b0;
      cal_value_q <= 24'h0;
    end else begin
      cal_value_q <= cal_q[cal_rd_idx];
      if (rd_req) begin
        hold_data_q <= data_q[rd_chan_q];
        hold_stat_q <= stat_q[rd_chan_q] |
                       {4'h0, ready_q[rd_chan_q], 3'h0};
        ack_tog_q <= ~ack_tog_q;
      end
    end
  end

  // Clock output and standby pins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mclk_div_q <= 1'b0;
      mclk_out_q <= 1'b0;
      mclk_out_oe_n_q <= 1'b0;
      powerdown_q <= 1'b0;
    end else begin
      mclk_div_q <= ~mclk_div_q;
      mclk_out_q <= mclk_div_q & ~mode_q[`AOM_CLOCK_OUTPUT_DISABLE_BIT];
      mclk_out_oe_n_q <= mode_q[`AOM_CLOCK_OUTPUT_DISABLE_BIT];
      powerdown_q <= (state_q == AOM_ST_STBY);
    end
  end

  // ****************************************
  // Link domain: answers and readout format
  // ****************************************
  // Sync of answer and mode-change toggles
  always_ff @(posedge link_clock) begin
    if (lrst_q) begin
      {ack_s1_q, ack_s2_q, ack_s3_q} <= 3'h0;
      {mt_s1_q, mt_s2_q, mt_s3_q} <= 3'h0;
      link_mode_rdata_q <= `AOM_MODE_RESET;
    end else begin
      {ack_s1_q, ack_s2_q, ack_s3_q} <= {ack_tog_q, ack_s1_q, ack_s2_q};
      {mt_s1_q, mt_s2_q, mt_s3_q} <= {mode_tog_q, mt_s1_q, mt_s2_q};
      if (mt_s2_q ^ mt_s3_q) begin
        // Mode word has been still since its toggle flipped
        link_mode_rdata_q <= mode_q;
      end
    end
  end

  // Read data presented to the serial shifter
  always_ff @(posedge link_clock) begin
    if (lrst_q) begin
      link_rd_valid_q <= 1'b0;
      link_rd_status_q <= 8'h0;
      link_rd_data_q <= 24'h0;
      link_rd_with_status_q <= 1'b0;
      link_rd_wide_q <= 1'b0;
      link_cont_read_q <= 1'b0;
    end else begin
      link_rd_valid_q <= ack_s2_q ^ ack_s3_q;
      if (ack_s2_q ^ ack_s3_q) begin
        link_rd_status_q <= hold_stat_q;
        link_rd_data_q <= hold_data_q;
      end
      link_rd_with_status_q <= link_mode_rdata_q[`AOM_DUMP_BIT] |
        link_mode_rdata_q[`AOM_CONTRD_BIT];
      link_rd_wide_q <= link_mode_rdata_q[`AOM_WIDE_BIT];
      link_cont_read_q <= link_mode_rdata_q[`AOM_CONTRD_BIT];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_wr_seen;
    mode_wr;
  endsequence

  property p_clock_output_disable_tristate;
    @(posedge clock) disable iff (sys_rst)
      mode_q[`AOM_CLOCK_OUTPUT_DISABLE_BIT] |=> mclk_out_oe_n_q && !mclk_out_q;
  endproperty
  a_clock_output_disable_tristate: assert property (p_clock_output_disable_tristate)
    else $error("clock output driven while disabled");

  property p_ext_clk_runs;
    @(posedge clock) disable iff (sys_rst)
      (!xt_s2_q && state_q == AOM_ST_RUN && cnt_q != 16'h0 && !mode_wr)
      |=> cnt_q == 16'($past(cnt_q) - 16'h1);
  endproperty
  a_ext_clk_runs: assert property (p_ext_clk_runs)
    else $error("conversion stalled with external clock");

  property p_xtal_halt;
    @(posedge clock) disable iff (sys_rst)
      (xt_s2_q && mode_q[`AOM_CLOCK_OUTPUT_DISABLE_BIT] && !mode_wr) |=>
      $stable(cnt_q) && $stable(state_q) &&
      ((ready_q & ~$past(ready_q)) == 8'h00);
  endproperty
  a_xtal_halt: assert property (p_xtal_halt)
    else $error("conversion ran with crystal clock stopped");

  property p_oneshot_idle;
    @(posedge clock) disable iff (sys_rst)
      (op_done && code != AOM_CONT && !mode_wr) |=>
      state_q == AOM_ST_IDLE && mode_q[`AOM_CODE_HI:`AOM_CODE_LO] == 3'h0;
  endproperty
  a_oneshot_idle: assert property (p_oneshot_idle)
    else $error("engine not idle after single or calibration");

  property p_scan_next;
    @(posedge clock) disable iff (sys_rst)
      (op_done && code == AOM_CONT && !mode_wr) |=>
      cur_ch_q == $past(adv_ch) && cnt_q == CONV_CYC;
  endproperty
  a_scan_next: assert property (p_scan_next)
    else $error("scan did not move to next enabled channel");

  property p_single_ready;
    @(posedge clock) disable iff (sys_rst)
      (store_ok && code == AOM_SINGLE && !mode_wr) |=>
      !rdy_n_q && ready_q[$past(cur_ch_q)];
  endproperty
  a_single_ready: assert property (p_single_ready)
    else $error("single conversion did not raise ready");

  property p_cal_all_ready;
    @(posedge clock) disable iff (sys_rst)
      (is_cal && !mode_wr) |=> ready_q == 8'hff && !rdy_n_q;
  endproperty
  a_cal_all_ready: assert property (p_cal_all_ready)
    else $error("calibration did not set all flags");

  property p_write_clears;
    @(posedge clock) disable iff (sys_rst)
      s_wr_seen |=> ready_q == 8'h00 && rdy_n_q &&
      mode_q == $past(wr_data_q);
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("mode write did not clear flags");

  property p_read_clears;
    @(posedge clock) disable iff (sys_rst)
      (rd_req && !mode_wr && !is_cal && !(store_ok && !rd_lock)) |=>
      !ready_q[$past(rd_chan_q)];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("data read left its flag set");

  property p_standby_pin;
    @(posedge clock) disable iff (sys_rst)
      state_q == AOM_ST_STBY |=> powerdown_q;
  endproperty
  a_standby_pin: assert property (p_standby_pin)
    else $error("standby did not power down");

endmodule

`default_nettype wire

/* inc/aom_defs.svh */
`ifndef AOM_DEFS_SVH
`define AOM_DEFS_SVH

// ****************************************
// Mode register layout
// ****************************************
`define AOM_MODE_RESET 8'h00
`define AOM_MODE_BASE_ADDR 8'h38
`define AOM_CODE_HI 7
`define AOM_CODE_LO 5
`define AOM_CLOCK_OUTPUT_DISABLE_BIT 4
`define AOM_DUMP_BIT 3
`define AOM_CONTRD_BIT 2
`define AOM_WIDE_BIT 1
`define AOM_CLAMP_BIT 0

// ****************************************
// Channel status byte layout
// ****************************************
`define AOM_STAT_CH_HI 7
`define AOM_STAT_CH_LO 5
`define AOM_STAT_RDY_BIT 3
`define AOM_STAT_OVER_BIT 1
`define AOM_STAT_UNDER_BIT 0

// ****************************************
// Timing
// ****************************************
`define AOM_CLK_FREQ_MHZ 100
`define AOM_CONV_TIME_US 20
`define AOM_CAL_TIME_US 40
`define AOM_CONV_CYC (`AOM_CONV_TIME_US * `AOM_CLK_FREQ_MHZ)
`define AOM_CAL_CYC (`AOM_CAL_TIME_US * `AOM_CLK_FREQ_MHZ)

`endif

/* inc/aom_pkg.sv */
package aom_pkg;

  // ****************************************
  // Operating mode codes
  // ****************************************
  typedef enum logic [2:0] {
    AOM_IDLE    = 3'h0,
    AOM_CONT    = 3'h1,
    AOM_SINGLE  = 3'h2,
    AOM_STANDBY = 3'h3,
    AOM_SELF_ZS = 3'h4,
    AOM_SELF_FS = 3'h5,
    AOM_SYS_ZS  = 3'h6,
    AOM_SYS_FS  = 3'h7
  } aom_code_t;

  // ****************************************
  // Engine states, Gray along idle-run-standby
  // ****************************************
  typedef enum logic [1:0] {
    AOM_ST_IDLE = 2'h0,
    AOM_ST_RUN  = 2'h1,
    AOM_ST_STBY = 2'h3
  } aom_state_t;

endpackage

/* verif/aom_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host side of the serial link
// ****************************************
module aom_host_model (
  // Link clock
  input wire logic link_clock,
  // Mode register write
  output logic link_mode_wr,
  output logic [2:0] link_mode_addr,
  output logic [7:0] link_mode_wdata,
  // Channel data read
  output logic link_data_rd,
  output logic [2:0] link_rd_chan,
  input wire logic link_rd_valid_q
);

  // Idle lines at time zero
  initial begin
    link_mode_wr = 1'b0;
    link_mode_addr = 3'h0;
    link_mode_wdata = 8'h00;
    link_data_rd = 1'b0;
    link_rd_chan = 3'h0;
  end

  // One write pulse; released lines carry the inverse afterwards
  task automatic write_mode(input logic [2:0] addr, input logic [7:0] val);
    @(posedge link_clock);
    #1;
    link_mode_wr = 1'b1;
    link_mode_addr = addr;
    link_mode_wdata = val;
    @(posedge link_clock);
    #1;
    link_mode_wr = 1'b0;
    link_mode_addr = ~addr;
    link_mode_wdata = ~val;
  endtask

  // Read request, then a bounded wait for the answer pulse
  task automatic read_chan(input logic [2:0] chan, output logic ok);
    int n;
    @(posedge link_clock);
    #1;
    link_data_rd = 1'b1;
    link_rd_chan = chan;
    @(posedge link_clock);
    #1;
    link_data_rd = 1'b0;
    link_rd_chan = ~chan;
    ok = 1'b0;
    for (n = 0; n < 60 && !ok; n++) begin
      @(negedge link_clock);
      // Answer stands one link cycle
      if (link_rd_valid_q === 1'b1) begin
        ok = 1'b1;
      end
    end
  endtask

endmodule

`default_nettype wire

/* verif/tb_adc_operating_mode_control.sv */
`include "aom_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Bench for the operating mode controller
// ****************************************
module tb_adc_operating_mode_control
  import aom_pkg::*;
;
  // Clocks, reset and stimulus
  logic clock, sys_rst, link_clock;
  logic [23:0] adc_result;
  logic adc_over, adc_under, xtal_mode, ok, m;
  logic [7:0] chan_enable;
  logic [4:0] cal_sel;
  // Link wires
  wire link_mode_wr, link_data_rd, link_rd_valid_q;
  wire [2:0] link_mode_addr, link_rd_chan;
  wire [7:0] link_mode_wdata, link_mode_rdata_q, link_rd_status_q;
  wire [23:0] link_rd_data_q, cal_value_q;
  wire link_rd_with_status_q, link_rd_wide_q, link_cont_read_q;
  wire rdy_n_q, mclk_out_q, mclk_out_oe_n_q, powerdown_q;
  // Bookkeeping
  int err_count, comparisons, c, t1, t2, k;
  int cycles = 0;

  aom_top dut (.clock, .sys_rst, .link_clock, .link_mode_wr,
    .link_mode_addr, .link_mode_wdata, .link_data_rd, .link_rd_chan,
    .link_mode_rdata_q, .link_rd_valid_q, .link_rd_status_q,
    .link_rd_data_q, .link_rd_with_status_q, .link_rd_wide_q,
    .link_cont_read_q, .adc_result, .adc_over, .adc_under, .chan_enable,
    .xtal_mode, .cal_sel, .cal_value_q, .rdy_n_q, .mclk_out_q,
    .mclk_out_oe_n_q, .powerdown_q);

  aom_host_model host (.link_clock, .link_mode_wr, .link_mode_addr,
    .link_mode_wdata, .link_data_rd, .link_rd_chan, .link_rd_valid_q);

  // Master clock, 10 ns
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Link clock, 6 ns, offset phase
  initial begin
    link_clock = 1'b0;
    #2.3;
    forever #3 link_clock = ~link_clock;
  end

  // Verdict and end of run
  task automatic complete_run;
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      complete_run();
    end
  end

  // Compare and count
  task automatic check(input string name, input logic [23:0] seen,
                       input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Step just past a clock edge
  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  // Mode write, then time for the crossing
  task automatic mode_wr(input logic [2:0] a, input logic [7:0] v);
    host.write_mode(a, v);
    repeat (12) @(posedge clock);
    #1;
  endtask

  // Bounded wait for the ready pin low
  task automatic wait_rdy(input int lim);
    c = 0;
    while (rdy_n_q !== 1'b0 && c < lim) begin
      @(negedge clock);
      c++;
    end
  endtask

  // Channel read through the host
  task automatic rd(input logic [2:0] ch);
    host.read_chan(ch, ok);
    check("read answer", 24'(ok), 24'h1);
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    adc_result = 24'h3c5a96;
    adc_over = 1'b0;
    adc_under = 1'b0;
    chan_enable = 8'h00;
    xtal_mode = 1'b0;
    cal_sel = 5'h00;
    err_count = 0;
    comparisons = 0;
    repeat (16) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    repeat (10) tick();
    check("rdy_n reset", 24'(rdy_n_q), 24'h1);
    check("oe_n reset", 24'(mclk_out_oe_n_q), 24'h0);
    check("mode reset", 24'(link_mode_rdata_q), 24'h0);
    // Single conversion on a disabled channel, 24 bits
    mode_wr(3'h5, {AOM_SINGLE, 5'h02});
    check("rdy_n on write", 24'(rdy_n_q), 24'h1);
    wait_rdy(2500);
    check("single done", 24'(rdy_n_q), 24'h0);
    rd(3'h5);
    check("status ch5", 24'(link_rd_status_q), 24'ha8);
    check("data ch5", link_rd_data_q, 24'h3c5a96);
    check("wide", 24'(link_rd_wide_q), 24'h1);
    check("separate", 24'(link_rd_with_status_q), 24'h0);
    check("mode idle", 24'(link_mode_rdata_q), 24'h02);
    check("rdy_n read", 24'(rdy_n_q), 24'h1);
    // Clamped over-range, 16 bits, combined readout
    tick();
    adc_over = 1'b1;
    mode_wr(3'h2, {AOM_SINGLE, 5'h09});
    wait_rdy(2500);
    rd(3'h2);
    check("status ch2", 24'(link_rd_status_q), 24'h4a);
    check("clamped", link_rd_data_q, 24'h00ffff);
    check("narrow", 24'(link_rd_wide_q), 24'h0);
    check("combined", 24'(link_rd_with_status_q), 24'h1);
    tick();
    adc_over = 1'b0;
    // Continuous read flag
    mode_wr(3'h0, 8'h04);
    check("cont read", 24'(link_cont_read_q), 24'h1);
    check("cont status", 24'(link_rd_with_status_q), 24'h1);
    // Clock output and standby
    mode_wr(3'h0, 8'h10);
    check("oe_n off", 24'(mclk_out_oe_n_q), 24'h1);
    check("clk out low", 24'(mclk_out_q), 24'h0);
    mode_wr(3'h0, {AOM_STANDBY, 5'h10});
    check("standby", 24'(powerdown_q), 24'h1);
    check("stby oe_n", 24'(mclk_out_oe_n_q), 24'h1);
    mode_wr(3'h0, {AOM_STANDBY, 5'h00});
    check("stby oe_n on", 24'(mclk_out_oe_n_q), 24'h0);
    @(negedge clock);
    m = mclk_out_q;
    @(negedge clock);
    check("clk toggles", 24'(mclk_out_q ^ m), 24'h1);
    mode_wr(3'h0, 8'h00);
    check("awake", 24'(powerdown_q), 24'h0);
    // Crystal with clock output off halts, external clock resumes
    tick();
    xtal_mode = 1'b1;
    mode_wr(3'h0, {AOM_SINGLE, 5'h12});
    wait_rdy(2500);
    check("xtal halt", 24'(rdy_n_q), 24'h1);
    tick();
    xtal_mode = 1'b0;
    wait_rdy(2500);
    check("ext converts", 24'(rdy_n_q), 24'h0);
    rd(3'h0);
    check("status ch0", 24'(link_rd_status_q), 24'h08);
    // All four calibrations
    for (k = 0; k < 4; k++) begin
      tick();
      adc_result = 24'h100000 + 24'(k);
      cal_sel = (k < 2) ? 5'(k) : 5'(8 * k - 10);
      mode_wr(3'h4, {3'(4 + k), 5'h00});
      wait_rdy(4500);
      check("cal done", 24'(rdy_n_q), 24'h0);
      // Readout register trails the store by one clock
      tick();
      check("cal value", cal_value_q, adc_result);
      rd(3'h7);
      check("all flags", 24'(link_rd_status_q[3]), 24'h1);
      check("cal idle", 24'(link_mode_rdata_q[7:5]), 24'h0);
    end
    // Continuous scan over channels 1 and 3
    tick();
    chan_enable = 8'h0a;
    mode_wr(3'h1, {AOM_CONT, 5'h02});
    wait_rdy(2500);
    t1 = cycles;
    rd(3'h1);
    check("scan ch1", 24'(link_rd_status_q), 24'h28);
    wait_rdy(2500);
    t2 = cycles - t1;
    rd(3'h3);
    check("scan ch3", 24'(link_rd_status_q), 24'h68);
    check("step", 24'(t2 > `AOM_CONV_CYC - 8 && t2 < `AOM_CONV_CYC + 8),
          24'h1);
    wait_rdy(2500);
    t2 = cycles - t1;
    check("period", 24'(t2 > 2 * `AOM_CONV_CYC - 8 &&
          t2 < 2 * `AOM_CONV_CYC + 8), 24'h1);
    // Write aborts the scan and releases the pin
    mode_wr(3'h0, 8'h00);
    check("abort", 24'(rdy_n_q), 24'h1);
    wait_rdy(2500);
    check("stays idle", 24'(rdy_n_q), 24'h1);
    complete_run();
  end

endmodule

`default_nettype wire
